// >>> src/sram_boundary_scan_tap.sv
/*
  Boundary-scan test port of a burst memory: controller, instruction
  path, bypass, identification and 109-cell boundary chain, plus the
  hand-over of pin control into the memory's system clock domain.
  Assumes tck_i, tms_i and tdi_i come from an outside test controller;
  ring_i are the pin levels of the ring, asynchronous to both clocks;
  the memory core uses ring_drive_o, ring_drive_sel_o and q_bus_oe_o.
  // Function
  // - paths: 3-bit instruction, 1-bit bypass, 32-bit identity, 109 cells
  // - code 000 captures ring contents into the boundary chain
  // - identify instruction loads fixed identity word and shifts it out
  // - code 010 captures ring, chains boundary cells, floats output bus
  // - code 100 captures ring, chains boundary cells, memory unaffected
  // - code 111 chains the one-bit bypass, memory unaffected
  // - identity word: revision 31:29, device 28:12, vendor 11:1
  // - identity bit 0 always one
  // - serial output changes after the falling test clock edge
  // - cell 108 high drives output bus under external test, low floats it
  // - cell 108 preset high at power-up and in test-logic-reset
  // - identify instruction becomes current at power-up and reset state
  // - boundary chain msb at tdi, lsb at tdo, bit 0 leaves first
*/
`timescale 1ns/1ps

`include "tap_defs.svh"

module sram_boundary_scan_tap #(
  parameter logic [2:0]  REV_CODE    = 3'h5,     // arbitrary value
  parameter logic [16:0] DEVICE_CODE = 17'h0A5A5, // arbitrary value
  parameter logic [10:0] VENDOR_CODE = 11'h2B3    // arbitrary value
) (
  input  wire logic                sys_clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                tck_i,
  input  wire logic                tms_i,
  input  wire logic                tdi_i,
  output logic                     tdo_o,
  output logic                     tdo_oe_o,
  input  wire logic [`RING_W-1:0]  ring_i,
  output logic      [`RING_W-1:0]  ring_drive_o,
  output logic                     ring_drive_sel_o,
  output logic                     q_bus_oe_o
);

  import tap_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic                  tck_rst_meta_ff;
  logic                  tck_rst_n_ff;
  tap_state_type         state;
  logic [`RING_W-1:0]    ring_sampled;

  logic [`IR_W-1:0]      test_instruction_shift_ff;
  op_type                test_instruction_ff;
  logic                  single_bit_bypass_ff;
  logic [`ID_W-1:0]      part_identification_ff;
  logic [`BSR_W-1:0]     pin_scan_chain_ff;
  logic [`BSR_W-1:0]     preload_ff;
  id_word_type           id_word;

  logic                  serial_bit;
  logic                  tdo_ff;
  logic                  tdo_oe_ff;

  pin_ctrl_type          nxt_ctrl;
  pin_ctrl_type          ctrl_ff;
  logic                  ctrl_toggle_ff;

  logic                  toggle_sys;
  logic                  toggle_seen_ff;
  pin_ctrl_type          sys_ctrl_ff;
  logic [`RING_W-1:0]    ring_drive_ff;
  logic                  ring_drive_sel_ff;
  logic                  q_bus_oe_ff;

  //////////////////////////////////////////////////////////////////////////
  // test clock reset: asserted at once, released on the test clock so the
  // controller never sees a half-released reset

  always_ff @(posedge tck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tck_rst_meta_ff <= 1'b0;
      tck_rst_n_ff    <= 1'b0;
    end else begin
      tck_rst_meta_ff <= 1'b1;
      tck_rst_n_ff    <= tck_rst_meta_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // controller and ring sampling

  // tms is taken on the rising edge inside the controller
  tap_fsm u_fsm (
    .tck_i   (tck_i),
    .rst_n_i (tck_rst_n_ff),
    .tms_i   (tms_i),
    .state_o (state)
  );

  // ring pins are asynchronous; a level moving at capture may read
  // either way, which only costs repeatability
  tap_sync #(
    .WIDTH (`RING_W)
  ) u_ring_sync (
    .clk_i   (tck_i),
    .rst_n_i (tck_rst_n_ff),
    .d_i     (ring_i),
    .q_o     (ring_sampled)
  );

  //////////////////////////////////////////////////////////////////////////
  // instruction path

  // capture fixed pattern, shift lsb first toward tdo
  always_ff @(posedge tck_i or negedge tck_rst_n_ff) begin
    if (!tck_rst_n_ff) begin
      test_instruction_shift_ff <= `IR_CAPTURE;
    end else if (state == ST_CAP_IR) begin
      test_instruction_shift_ff <= `IR_CAPTURE;
    end else if (state == ST_SHIFT_IR) begin
      test_instruction_shift_ff <= {tdi_i,
        test_instruction_shift_ff[`IR_W-1:1]};
    end
  end

  // current instruction changes only on leaving update-ir or in test-logic-reset; reserved
  // codes are accepted but behave as bypass
  always_ff @(posedge tck_i or negedge tck_rst_n_ff) begin
    if (!tck_rst_n_ff) begin
      test_instruction_ff <= OP_IDENTIFY;
    end else if (state == ST_RESET) begin
      test_instruction_ff <= OP_IDENTIFY;
    end else if (state == ST_UPD_IR) begin
      test_instruction_ff <= op_type'(test_instruction_shift_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bypass path

  always_ff @(posedge tck_i or negedge tck_rst_n_ff) begin
    if (!tck_rst_n_ff) begin
      single_bit_bypass_ff <= `BYPASS_CAPTURE;
    end else if (state == ST_CAP_DR) begin
      single_bit_bypass_ff <= `BYPASS_CAPTURE;
    end else if (state == ST_SHIFT_DR) begin
      single_bit_bypass_ff <= tdi_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // identification path

  // fixed word, presence bit tied high
  assign id_word.revision = REV_CODE;
  assign id_word.device   = DEVICE_CODE;
  assign id_word.vendor   = VENDOR_CODE;
  assign id_word.present  = `ID_PRESENT;

  // loaded only under the identify instruction; memory untouched
  always_ff @(posedge tck_i or negedge tck_rst_n_ff) begin
    if (!tck_rst_n_ff) begin
      part_identification_ff <= '0;
    end else if (state == ST_CAP_DR &&
                 test_instruction_ff == OP_IDENTIFY) begin
      part_identification_ff <= id_word;
    end else if (state == ST_SHIFT_DR &&
                 test_instruction_ff == OP_IDENTIFY) begin
      part_identification_ff <= {tdi_i,
        part_identification_ff[`ID_W-1:1]};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // boundary chain

  // capture ring pins plus the control cell's latched value, then shift
  // with msb at tdi so cell 0 leaves first
  always_ff @(posedge tck_i or negedge tck_rst_n_ff) begin
    if (!tck_rst_n_ff) begin
      pin_scan_chain_ff <= '0;
    end else if (state == ST_CAP_DR &&
                 uses_ring(test_instruction_ff)) begin
      pin_scan_chain_ff <= {preload_ff[`HIZ_CELL],
                            ring_sampled};
    end else if (state == ST_SHIFT_DR &&
                 uses_ring(test_instruction_ff)) begin
      pin_scan_chain_ff <= {tdi_i,
        pin_scan_chain_ff[`BSR_W-1:1]};
    end
  end

  // latched cells: update-dr copies the chain; the control cell alone
  // is preset in reset so the output bus stays enabled by default
  always_ff @(posedge tck_i or negedge tck_rst_n_ff) begin
    if (!tck_rst_n_ff) begin
      preload_ff            <= '0;
      preload_ff[`HIZ_CELL] <= `HIZ_CELL_RESET;
    end else if (state == ST_RESET) begin
      preload_ff[`HIZ_CELL] <= `HIZ_CELL_RESET;
    end else if (state == ST_UPD_DR &&
                 uses_ring(test_instruction_ff)) begin
      preload_ff <= pin_scan_chain_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial output

  // pick the bit standing at the tdo end of the active path
  always_comb begin
    if (state == ST_SHIFT_IR) begin
      serial_bit = test_instruction_shift_ff[0];
    end else if (test_instruction_ff == OP_IDENTIFY) begin
      serial_bit = part_identification_ff[0];
    end else if (uses_ring(test_instruction_ff)) begin
      serial_bit = pin_scan_chain_ff[0];
    end else begin
      serial_bit = single_bit_bypass_ff;
    end
  end

  // falling edge gives the far end a full half period of setup
  always_ff @(negedge tck_i or negedge tck_rst_n_ff) begin
    if (!tck_rst_n_ff) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff    <= serial_bit;
      tdo_oe_ff <= (state == ST_SHIFT_IR) ||
                   (state == ST_SHIFT_DR);
    end
  end

  assign tdo_o    = tdo_ff;
  assign tdo_oe_o = tdo_oe_ff;

  //////////////////////////////////////////////////////////////////////////
  // pin control word, test clock side

  // only external test and sample-hiz touch the memory's pins
  always_comb begin
    nxt_ctrl.ext_test   = (test_instruction_ff == OP_EXT_TEST);
    nxt_ctrl.sample_hiz = (test_instruction_ff == OP_SAMPLE_HIZ);
    nxt_ctrl.preload    = preload_ff;
  end

  // the word is held steady and a toggle flags each change; updates are
  // several test clocks apart, far longer than the sync latency
  always_ff @(posedge tck_i or negedge tck_rst_n_ff) begin
    if (!tck_rst_n_ff) begin
      ctrl_ff                     <= '0;
      ctrl_ff.preload[`HIZ_CELL]  <= `HIZ_CELL_RESET;
      ctrl_toggle_ff              <= 1'b0;
    end else begin
      ctrl_ff        <= nxt_ctrl;
      ctrl_toggle_ff <= ctrl_toggle_ff ^ (nxt_ctrl != ctrl_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin control word, system clock side

  tap_sync #(
    .WIDTH (1)
  ) u_toggle_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (reset_n_i),
    .d_i     (ctrl_toggle_ff),
    .q_o     (toggle_sys)
  );

  // output bus enable from the control word
  function automatic logic bus_enable(input pin_ctrl_type c);
    if (c.sample_hiz) begin
      bus_enable = 1'b0;
    end else if (c.ext_test) begin
      bus_enable = c.preload[`HIZ_CELL];
    end else begin
      bus_enable = 1'b1;
    end
  endfunction

  // take the word once its toggle has settled in this domain
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      toggle_seen_ff                 <= 1'b0;
      sys_ctrl_ff                    <= '0;
      sys_ctrl_ff.preload[`HIZ_CELL] <= `HIZ_CELL_RESET;
    end else if (toggle_sys != toggle_seen_ff) begin
      toggle_seen_ff <= toggle_sys;
      sys_ctrl_ff    <= ctrl_ff;
    end
  end

  // registered pin controls toward the memory core
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ring_drive_ff     <= '0;
      ring_drive_sel_ff <= 1'b0;
      q_bus_oe_ff       <= 1'b1;
    end else begin
      ring_drive_ff     <= sys_ctrl_ff.preload[`RING_W-1:0];
      ring_drive_sel_ff <= sys_ctrl_ff.ext_test;
      q_bus_oe_ff       <= bus_enable(sys_ctrl_ff);
    end
  end

  assign ring_drive_o     = ring_drive_ff;
  assign ring_drive_sel_o = ring_drive_sel_ff;
  assign q_bus_oe_o       = q_bus_oe_ff;

endmodule

// >>> src/tap_defs.svh
/*
  Constants of the boundary-scan test port: scan path widths, instruction
  codes, identification field positions and reset values.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH

// scan path widths
`define IR_W             3
`define ID_W             32
`define BSR_W            109
`define RING_W           108
`define HIZ_CELL         108

// instruction codes
`define OPC_EXT_TEST     3'h0
`define OPC_IDENTIFY     3'h1
`define OPC_SAMPLE_HIZ   3'h2
`define OPC_RSV3         3'h3
`define OPC_PRELOAD      3'h4
`define OPC_RSV5         3'h5
`define OPC_RSV6         3'h6
`define OPC_BYPASS       3'h7

// capture and reset values
`define IR_CAPTURE       3'h1
`define BYPASS_CAPTURE   1'h0
`define ID_PRESENT       1'h1
`define HIZ_CELL_RESET   1'h1

// identification field positions
`define ID_REV_MSB       31
`define ID_REV_LSB       29
`define ID_DEV_MSB       28
`define ID_DEV_LSB       12
`define ID_VEN_MSB       11
`define ID_VEN_LSB       1
`define ID_PRES_BIT      0

`endif

// >>> src/tap_fsm.sv
/*
  Sixteen-state test access controller.
  Assumes tms_i is set up to the rising edge of tck_i by the controller
  outside; reset is asserted asynchronously and released on tck_i.
*/
`timescale 1ns/1ps

module tap_fsm (
  input  wire logic              tck_i,
  input  wire logic              rst_n_i,
  input  wire logic              tms_i,
  output tap_pkg::tap_state_type state_o
);

  import tap_pkg::*;

  tap_state_type state_ff;
  tap_state_type nxt_state;

  // next state steered by tms
  always_comb begin
    unique case (state_ff)
      ST_RESET:    nxt_state = tms_i ? ST_RESET    : ST_IDLE;
      ST_IDLE:     nxt_state = tms_i ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   nxt_state = tms_i ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   nxt_state = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: nxt_state = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: nxt_state = tms_i ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: nxt_state = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: nxt_state = tms_i ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   nxt_state = tms_i ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   nxt_state = tms_i ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   nxt_state = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: nxt_state = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: nxt_state = tms_i ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: nxt_state = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: nxt_state = tms_i ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   nxt_state = tms_i ? ST_SEL_DR   : ST_IDLE;
    endcase
  end

  // state register, rising edge of the test clock
  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign state_o = state_ff;

endmodule

// >>> src/tap_pkg.sv
/*
  Types of the boundary-scan test port: controller states, instruction
  codes, identification word layout and the control word that crosses
  from the test clock to the system clock.
  Assumes tap_defs.svh is on the include path.
*/
`include "tap_defs.svh"

package tap_pkg;

  // sixteen controller states
  typedef enum logic [3:0] {
    ST_RESET      = 4'b0000,
    ST_IDLE       = 4'b0001,
    ST_SEL_DR     = 4'b0010,
    ST_CAP_DR     = 4'b0011,
    ST_SHIFT_DR   = 4'b0100,
    ST_EXIT1_DR   = 4'b0101,
    ST_PAUSE_DR   = 4'b0110,
    ST_EXIT2_DR   = 4'b0111,
    ST_UPD_DR     = 4'b1000,
    ST_SEL_IR     = 4'b1001,
    ST_CAP_IR     = 4'b1010,
    ST_SHIFT_IR   = 4'b1011,
    ST_EXIT1_IR   = 4'b1100,
    ST_PAUSE_IR   = 4'b1101,
    ST_EXIT2_IR   = 4'b1110,
    ST_UPD_IR     = 4'b1111
  } tap_state_type;

  // all eight codes, reserved ones included
  typedef enum logic [`IR_W-1:0] {
    OP_EXT_TEST   = `OPC_EXT_TEST,
    OP_IDENTIFY   = `OPC_IDENTIFY,
    OP_SAMPLE_HIZ = `OPC_SAMPLE_HIZ,
    OP_RSV3       = `OPC_RSV3,
    OP_PRELOAD    = `OPC_PRELOAD,
    OP_RSV5       = `OPC_RSV5,
    OP_RSV6       = `OPC_RSV6,
    OP_BYPASS     = `OPC_BYPASS
  } op_type;

  // identification word, msb first
  typedef struct packed {
    logic [`ID_REV_MSB-`ID_REV_LSB:0] revision;
    logic [`ID_DEV_MSB-`ID_DEV_LSB:0] device;
    logic [`ID_VEN_MSB-`ID_VEN_LSB:0] vendor;
    logic                             present;
  } id_word_type;

  // pin control handed to the system clock domain
  typedef struct packed {
    logic               ext_test;
    logic               sample_hiz;
    logic [`BSR_W-1:0]  preload;
  } pin_ctrl_type;

  // instructions that put the boundary chain in the path
  function automatic logic uses_ring(input op_type op);
    uses_ring = (op == OP_EXT_TEST) || (op == OP_SAMPLE_HIZ) ||
                (op == OP_PRELOAD);
  endfunction

endpackage

// >>> src/tap_sync.sv
/*
  Two flip-flop level synchroniser, any width.
  Assumes each bit is an independent level or a slow toggle; a word
  whose bits must agree is not to be passed through here alone.
*/
`timescale 1ns/1ps

module tap_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stable_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff   <= '0;
      stable_ff <= '0;
    end else begin
      meta_ff   <= d_i;
      stable_ff <= meta_ff;
    end
  end

  assign q_o = stable_ff;

endmodule

// >>> tb/sram_boundary_scan_tap_checker.sv
/*
  Checker of the boundary-scan test port, watching the top ports only.
  Assumes the test clock stops between frames and the system clock runs.
*/
`timescale 1ns/1ps
`include "tap_defs.svh"

module sram_boundary_scan_tap_checker (
  input wire logic               sys_clk_i,
  input wire logic               reset_n_i,
  input wire logic               tck_i,
  input wire logic               tms_i,
  input wire logic               tdi_i,
  input wire logic               tdo_o,
  input wire logic               tdo_oe_o,
  input wire logic [`RING_W-1:0] ring_i,
  input wire logic [`RING_W-1:0] ring_drive_o,
  input wire logic               ring_drive_sel_o,
  input wire logic               q_bus_oe_o
);
  logic       tck_q_ff;
  logic [3:0] quiet_ff;

  ////////////////////////////////////////////////////////////////////////////
  // sys cycles since tck last moved; saturates, so a stopped tck reads quiet
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tck_q_ff <= 1'b0;
      quiet_ff <= 4'h0;
    end else begin
      tck_q_ff <= tck_i;
      if (tck_i != tck_q_ff) begin
        quiet_ff <= 4'h0;
      end else if (quiet_ff != 4'hF) begin
        quiet_ff <= quiet_ff + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_tdo_hold: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    tck_i && $past(tck_i) |-> $stable(tdo_o))
    else $error("serial output moved while test clock high");
  chk_oe_edge: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    $changed(tdo_oe_o) |-> !tck_i)
    else $error("output enable moved outside low phase");
  chk_release_safe: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> q_bus_oe_o && !ring_drive_sel_o && !tdo_oe_o)
    else $error("pin control not at defaults after reset");
  // the crossing must settle within a few sys cycles of a tck edge
  chk_pin_quiet: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    quiet_ff > 4'h7 |-> $stable(ring_drive_o) && $stable(q_bus_oe_o)
      && $stable(ring_drive_sel_o))
    else $error("pin control moved with test clock stopped");
  chk_shift_entry: assert property (
    @(posedge tck_i) disable iff (!reset_n_i)
    $rose(tdo_oe_o) |-> !$past(tms_i))
    else $error("shift entered with mode select high");
  chk_shift_exit: assert property (
    @(posedge tck_i) disable iff (!reset_n_i)
    $fell(tdo_oe_o) |-> $past(tms_i))
    else $error("shift left with mode select low");
  chk_shift_stay: assert property (
    @(posedge tck_i) disable iff (!reset_n_i)
    tdo_oe_o && !tms_i |=> tdo_oe_o)
    else $error("shift left early");
  chk_tlr_defaults: assert property (
    @(posedge tck_i) disable iff (!reset_n_i)
    tms_i [*5] |-> ##3 q_bus_oe_o && !ring_drive_sel_o && !tdo_oe_o)
    else $error("reset state did not restore pin defaults");
endmodule

bind sram_boundary_scan_tap sram_boundary_scan_tap_checker
  sram_boundary_scan_tap_checker_inst (
  .sys_clk_i        (sys_clk_i),
  .reset_n_i        (reset_n_i),
  .tck_i            (tck_i),
  .tms_i            (tms_i),
  .tdi_i            (tdi_i),
  .tdo_o            (tdo_o),
  .tdo_oe_o         (tdo_oe_o),
  .ring_i           (ring_i),
  .ring_drive_o     (ring_drive_o),
  .ring_drive_sel_o (ring_drive_sel_o),
  .q_bus_oe_o       (q_bus_oe_o)
);

// >>> tb/sram_boundary_scan_tap_test.sv
/*
  Self-checking bench of the boundary-scan test port.
  Assumes the host model drives the test pins and the bench the ring.
*/
`timescale 1ns/1ps
`include "tap_defs.svh"

module sram_boundary_scan_tap_test;
  localparam logic [2:0]  REV = 3'h6;     // arbitrary value
  localparam logic [16:0] DEV = 17'h1C3E7; // arbitrary value
  localparam logic [10:0] VEN = 11'h4D1;  // arbitrary value
  localparam logic [31:0] ID_EXP = {REV, DEV, VEN, 1'h1};
  localparam logic [`RING_W-1:0] RING_A = {9{12'h3C5}};
  localparam logic [`RING_W-1:0] RING_B = {9{12'h5A6}};
  localparam logic [`RING_W-1:0] RING_C = {9{12'hC39}};

  logic               sys_clk_i;
  logic               reset_n_i;
  logic               tck;
  logic               tms;
  logic               tdi;
  logic               tdo_o;
  logic               tdo_oe_o;
  logic [`RING_W-1:0] ring_i;
  logic [`RING_W-1:0] ring_drive_o;
  logic               ring_drive_sel_o;
  logic               q_bus_oe_o;
  logic [`BSR_W-1:0]  d;
  int                 n_fail;
  int                 n_compared;

  ////////////////////////////////////////////////////////////////////////////
  sram_boundary_scan_tap #(
    .REV_CODE    (REV),
    .DEVICE_CODE (DEV),
    .VENDOR_CODE (VEN)
  ) sram_boundary_scan_tap_inst (
    .sys_clk_i        (sys_clk_i),
    .reset_n_i        (reset_n_i),
    .tck_i            (tck),
    .tms_i            (tms),
    .tdi_i            (tdi),
    .tdo_o            (tdo_o),
    .tdo_oe_o         (tdo_oe_o),
    .ring_i           (ring_i),
    .ring_drive_o     (ring_drive_o),
    .ring_drive_sel_o (ring_drive_sel_o),
    .q_bus_oe_o       (q_bus_oe_o)
  );

  tap_host_model tap_host_model_inst (
    .tck_o (tck),
    .tms_o (tms),
    .tdi_o (tdi),
    .tdo_i (tdo_o)
  );

  // 200 MHz system clock
  always #2.5 sys_clk_i = ~sys_clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [`BSR_W-1:0] seen, input logic
                       [`BSR_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // bounded wait for the pin control word to cross, then compare it
  task automatic wait_pins(input logic sel, input logic oe);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge sys_clk_i);
      #1;
      if (ring_drive_sel_o === sel && q_bus_oe_o === oe) break;
    end
    if (i == 60) begin
      n_fail++;
      $display("[ERR] %0t: pin control did not settle", $time);
      report_and_stop();
    end
    check(`BSR_W'({ring_drive_sel_o, q_bus_oe_o}), `BSR_W'({sel, oe}));
  endtask

  task automatic load_ir(input logic [2:0] code);
    tap_host_model_inst.scan(1'b1, 3, `BSR_W'(code), d);
  endtask

  task automatic scan_dr(input int len, input logic [`BSR_W-1:0] din);
    tap_host_model_inst.scan(1'b0, len, din, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    reset_n_i = 1'b0;
    ring_i = RING_A;
    n_fail = 0;
    n_compared = 0;
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    check(`BSR_W'({tdo_oe_o, ring_drive_sel_o, q_bus_oe_o}), 109'h1);
    tap_host_model_inst.reset_tap();
    scan_dr(32, '0);
    check(d, `BSR_W'(ID_EXP));
    load_ir(3'h1);
    check(d, `BSR_W'(3'h1));
    scan_dr(32, '0);
    check(d, `BSR_W'(ID_EXP));
    check(`BSR_W'(d[0]), `BSR_W'(1'h1));
    $display("test identify done");
    // bypass: captured zero first, then tdi one clock late
    load_ir(3'h7);
    scan_dr(8, `BSR_W'(8'hB5));
    check(d, `BSR_W'(8'h6A));
    wait_pins(1'b0, 1'b1);
    $display("test bypass done");
    // preload: ring captured lsb first, cell 108 still preset
    load_ir(3'h4);
    scan_dr(`BSR_W, {1'b0, RING_B});
    check(d, {1'b1, RING_A});
    wait_pins(1'b0, 1'b1);
    $display("test preload done");
    // external test drives the preloaded cells, cell 108 low floats bus
    @(posedge sys_clk_i) ring_i <= RING_C;
    load_ir(3'h0);
    wait_pins(1'b1, 1'b0);
    check(`BSR_W'(ring_drive_o), `BSR_W'(RING_B));
    scan_dr(`BSR_W, {1'b1, RING_A});
    check(d, {1'b0, RING_C});
    wait_pins(1'b1, 1'b1);
    $display("test extest done");
    load_ir(3'h2);
    wait_pins(1'b0, 1'b0);
    scan_dr(`BSR_W, '0);
    check(d, {1'b1, RING_C});
    $display("test sample hiz done");
    // reset state restores identify and presets cell 108 again
    tap_host_model_inst.reset_tap();
    wait_pins(1'b0, 1'b1);
    scan_dr(32, '0);
    check(d, `BSR_W'(ID_EXP));
    load_ir(3'h4);
    scan_dr(`BSR_W, '0);
    check(d, {1'b1, RING_C});
    $display("test logic reset done");
    // second reset in mid-run while external test floats the bus
    load_ir(3'h0);
    wait_pins(1'b1, 1'b0);
    @(posedge sys_clk_i) reset_n_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    #1;
    check(`BSR_W'({ring_drive_sel_o, q_bus_oe_o}), `BSR_W'(2'h1));
    @(posedge sys_clk_i) reset_n_i <= 1'b1;
    tap_host_model_inst.reset_tap();
    scan_dr(32, '0);
    check(d, `BSR_W'(ID_EXP));
    $display("test async reset done");
    report_and_stop();
  end
endmodule

// >>> tb/tap_host_model.sv
/*
  Outside test controller: makes the 32 ns test clock only within frames.
  Assumes the caller starts each task with the test clock low.
*/
`timescale 1ns/1ps

module tap_host_model (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  // idle levels before the first frame
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one test clock; inputs set a half period ahead of the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #16;
    tck_o = 1'b1;
    tdo = tdo_i;
    #16;
    tck_o = 1'b0;
  endtask

  // five or more highs reach the reset state from anywhere
  task automatic reset_tap;
    logic t;
    repeat (8) step(1'b1, ~tdi_o, t);
    step(1'b0, ~tdi_o, t);
  endtask

  // from idle: one scan of len bits, lsb first; unused tdi keeps toggling
  task automatic scan(input logic ir, input int len,
                      input logic [108:0] din, output logic [108:0] dout);
    logic t;
    int   i;
    dout = '0;
    // reserved codes are never shifted into the instruction path
    if (ir && (din[2:0] inside {3'h3, 3'h5, 3'h6})) return;
    step(1'b1, ~tdi_o, t);
    if (ir) step(1'b1, ~tdi_o, t);
    step(1'b0, ~tdi_o, t);
    step(1'b0, ~tdi_o, t);
    for (i = 0; i < len; i++) begin
      step(i == len - 1, din[i], t);
      dout[i] = t;
    end
    step(1'b1, ~tdi_o, t);
    // extra idle clocks let the pin control cross before tck stops
    repeat (3) step(1'b0, ~tdi_o, t);
  endtask
endmodule
